// *** hw/sfs_map.svh ***
/*
 * Constants of the steer fault supervisor: fault codes, timing figures
 * and table positions. Included by the package and the design modules;
 * assumes a single 25 MHz controller clock.
 */
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define SFS_CLK_PERIOD_NS   40
`define SFS_TICK_MS         1
`define SFS_MS_CYCLES       ((`SFS_TICK_MS * 1000000) / `SFS_CLK_PERIOD_NS)
`define SFS_FLASH_ON_MS     250
`define SFS_FLASH_OFF_MS    250
`define SFS_DIGIT_GAP_MS    750
`define SFS_REPEAT_GAP_MS   1500

// ---------------------------------------------------------------
// Fault codes and table positions
// ---------------------------------------------------------------
`define SFS_CODE_NONE       6'h00
`define SFS_CODE_OVERCUR    6'h0C
`define SFS_CODE_CUR_SENSE  6'h0D
`define SFS_CODE_PRECHARGE  6'h0E
`define SFS_CODE_UNDERTEMP  6'h0F
`define SFS_CODE_OVERTEMP   6'h10
`define SFS_CODE_SEVERE_17  6'h11
`define SFS_CODE_FIVE_VOLT  6'h18
`define SFS_NUM_FAULTS      7

`endif

// *** hw/sfs_pkg.sv ***
/*
 * Types of the steer fault supervisor.
 * Assumes sfs_map.svh is on the include path.
 */
`include "sfs_map.svh"

package sfs_pkg;

    // Steer fault actions, one-hot
    typedef enum logic [5:0] {
        SFS_ACT_WARN      = 6'h01,
        SFS_ACT_SHUTDOWN  = 6'h02,
        SFS_ACT_REDUCE    = 6'h04,
        SFS_ACT_MAX_ANGLE = 6'h08,
        SFS_ACT_WARN_SHUT = 6'h10,
        SFS_ACT_HOLD_SHUT = 6'h20
    } sfs_action_t;

    // Supervisor states, one-hot
    typedef enum logic [2:0] {
        SFS_ST_NORMAL = 3'h1,
        SFS_ST_DEFER  = 3'h2,
        SFS_ST_SHUT   = 3'h4
    } sfs_state_t;

    // One row of the fault table
    typedef struct packed {
        logic [5:0]  code;
        sfs_action_t action;
        logic        key_clear;
        logic        trac_stop;
    } sfs_fault_entry_t;

    // Control lines towards the steering stage and traction controller
    typedef struct packed {
        logic steer_enable;
        logic fault_out;
        logic reduced_current;
        logic angle_max;
        logic hold_position;
        logic traction_stop;
    } sfs_steer_ctl_t;

endpackage

// *** hw/sfs_flasher.sv ***
/*
 * Status LED flasher: flashes a two-digit fault code as tens pulses,
 * a gap, units pulses and a rest, repeating while a code is present.
 * Assumes a one-cycle millisecond tick on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfs_map.svh"

module sfs_flasher
    import sfs_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Code and time base
    input  wire logic       ms_tick,
    input  wire logic [5:0] code,
    // LED driver
    output logic            led
);

    typedef enum logic [4:0] {
        SFS_FL_IDLE = 5'h01,
        SFS_FL_ON   = 5'h02,
        SFS_FL_OFF  = 5'h04,
        SFS_FL_GAP  = 5'h08,
        SFS_FL_REST = 5'h10
    } sfs_flash_state_t;

    sfs_flash_state_t  state;
    logic [10:0]       ms_left;
    logic [3:0]        pulses;
    logic [3:0]        units;
    logic              on_units;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state    <= SFS_FL_IDLE;
            ms_left  <= 11'h000;
            pulses   <= 4'h0;
            units    <= 4'h0;
            on_units <= 1'b0;
        end
        else if (ms_tick && ms_left != 11'h000)
        begin
            ms_left <= ms_left - 11'h001;
        end
        else if (ms_tick)
        begin
            unique case (state)
                SFS_FL_IDLE:
                    if (code != `SFS_CODE_NONE)
                    begin
                        pulses   <= 4'(code / 6'h0A);
                        units    <= 4'(code % 6'h0A);
                        on_units <= 1'b0;
                        state    <= SFS_FL_ON;
                        ms_left  <= 11'(`SFS_FLASH_ON_MS - 1);
                    end
                SFS_FL_ON:
                begin
                    pulses  <= pulses - 4'h1;
                    state   <= SFS_FL_OFF;
                    ms_left <= 11'(`SFS_FLASH_OFF_MS - 1);
                end
                SFS_FL_OFF:
                    if (pulses != 4'h0)
                    begin
                        state   <= SFS_FL_ON;
                        ms_left <= 11'(`SFS_FLASH_ON_MS - 1);
                    end
                    else if (!on_units)
                    begin
                        state   <= SFS_FL_GAP;
                        ms_left <= 11'(`SFS_DIGIT_GAP_MS - 1);
                    end
                    else
                    begin
                        state   <= SFS_FL_REST;
                        ms_left <= 11'(`SFS_REPEAT_GAP_MS - 1);
                    end
                SFS_FL_GAP:
                begin
                    on_units <= 1'b1;
                    pulses   <= units;
                    if (units == 4'h0)
                    begin
                        state   <= SFS_FL_REST;
                        ms_left <= 11'(`SFS_REPEAT_GAP_MS - 1);
                    end
                    else
                    begin
                        state   <= SFS_FL_ON;
                        ms_left <= 11'(`SFS_FLASH_ON_MS - 1);
                    end
                end
                SFS_FL_REST:
                    state <= SFS_FL_IDLE;
                default:
                    state <= SFS_FL_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // LED output
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            led <= 1'b0;
        else
            led <= (state == SFS_FL_ON);
    end

endmodule // sfs_flasher
`default_nettype wire

// *** hw/sfs_supervisor.sv ***
/*
 * Steer fault supervisor: latches detected faults, applies each one's
 * steer and traction action, and flashes the active code on the LED.
 * Assumes fault detect levels come from logic on sys_clk, while the
 * keyswitch and traction-stopped levels arrive from pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfs_map.svh"

module sfs_supervisor
    import sfs_pkg::*;
#(
    parameter int NF        = `SFS_NUM_FAULTS,
    parameter int MS_CYCLES = `SFS_MS_CYCLES
)
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    // Fault detectors, table order
    input  wire logic [NF-1:0] fault_detect,
    // Pins from the vehicle
    input  wire logic          keyswitch_input,
    input  wire logic          traction_stopped,
    // Programmed fault steering timeout in ms
    input  wire logic [15:0]   fault_timeout_ms,
    // Control and status
    output sfs_steer_ctl_t     steer_ctl,
    output logic [5:0]         active_code,
    output logic [NF-1:0]      fault_latched,
    output logic               status_led
);

    // ---------------------------------------------------------------
    // Fault table
    // ---------------------------------------------------------------
    localparam sfs_fault_entry_t TABLE [0:`SFS_NUM_FAULTS-1] = '{
        '{`SFS_CODE_OVERCUR,   SFS_ACT_SHUTDOWN,  1'b1, 1'b1},
        '{`SFS_CODE_CUR_SENSE, SFS_ACT_SHUTDOWN,  1'b1, 1'b1},
        '{`SFS_CODE_PRECHARGE, SFS_ACT_SHUTDOWN,  1'b1, 1'b1},
        '{`SFS_CODE_UNDERTEMP, SFS_ACT_WARN,      1'b0, 1'b0},
        '{`SFS_CODE_OVERTEMP,  SFS_ACT_WARN_SHUT, 1'b1, 1'b1},
        '{`SFS_CODE_SEVERE_17, SFS_ACT_SHUTDOWN,  1'b1, 1'b1},
        '{`SFS_CODE_FIVE_VOLT, SFS_ACT_HOLD_SHUT, 1'b1, 1'b1}
    };

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_s3;
    logic [1:0] pin_level;
    logic       key_on;
    logic       trac_stop_seen;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1    <= 2'h0;
            pin_s2    <= 2'h0;
            pin_s3    <= 2'h0;
            pin_level <= 2'h0;
        end
        else
        begin
            pin_s1 <= {traction_stopped, keyswitch_input};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (int b = 0; b < 2; b++)
            begin
                if (pin_s2[b] == pin_s3[b])
                    pin_level[b] <= pin_s3[b];
            end
        end
    end

    assign key_on         = pin_level[0];
    assign trac_stop_seen = pin_level[1];

    // ---------------------------------------------------------------
    // Millisecond time base
    // ---------------------------------------------------------------
    logic [$clog2(MS_CYCLES)-1:0] ms_count;
    logic                         ms_tick;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ms_count <= '0;
            ms_tick  <= 1'b0;
        end
        else if (ms_count == $bits(ms_count)'(MS_CYCLES - 1))
        begin
            ms_count <= '0;
            ms_tick  <= 1'b1;
        end
        else
        begin
            ms_count <= ms_count + 1'b1;
            ms_tick  <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Fault latches
    // ---------------------------------------------------------------
    logic [NF-1:0] latched;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            latched <= '0;
        else
        begin
            for (int i = 0; i < NF; i++)
            begin
                // A new detection wins over any clear in the same cycle
                if (fault_detect[i])
                    latched[i] <= 1'b1;
                else if (TABLE[i].key_clear && !key_on)
                    latched[i] <= 1'b0;
                else if (!TABLE[i].key_clear)
                    latched[i] <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Action summary of all latched faults
    // ---------------------------------------------------------------
    logic any_shut;
    logic any_warn_shut;
    logic any_hold_shut;
    logic any_reduce;
    logic any_max_angle;
    logic any_trac_stop;

    always_comb
    begin
        any_shut      = 1'b0;
        any_warn_shut = 1'b0;
        any_hold_shut = 1'b0;
        any_reduce    = 1'b0;
        any_max_angle = 1'b0;
        any_trac_stop = 1'b0;
        for (int i = 0; i < NF; i++)
        begin
            if (latched[i])
            begin
                // Warning-only rows add nothing here
                unique case (TABLE[i].action)
                    SFS_ACT_WARN:      ;
                    SFS_ACT_SHUTDOWN:  any_shut      = 1'b1;
                    SFS_ACT_REDUCE:    any_reduce    = 1'b1;
                    SFS_ACT_MAX_ANGLE: any_max_angle = 1'b1;
                    SFS_ACT_WARN_SHUT: any_warn_shut = 1'b1;
                    SFS_ACT_HOLD_SHUT: any_hold_shut = 1'b1;
                endcase
                if (TABLE[i].trac_stop)
                    any_trac_stop = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Supervisor state
    // ---------------------------------------------------------------
    sfs_state_t  state;
    sfs_state_t  next_state;
    logic [15:0] defer_ms;
    logic        deferred;
    logic        defer_done;

    assign deferred   = any_warn_shut | any_hold_shut;
    assign defer_done = trac_stop_seen || (defer_ms >= fault_timeout_ms);

    always_comb
    begin
        next_state = state;
        unique case (state)
            SFS_ST_NORMAL:
                if (any_shut)
                    next_state = SFS_ST_SHUT;
                else if (deferred)
                    next_state = SFS_ST_DEFER;
            SFS_ST_DEFER:
                if (any_shut || (deferred && defer_done))
                    next_state = SFS_ST_SHUT;
                else if (!deferred)
                    next_state = SFS_ST_NORMAL;
            SFS_ST_SHUT:
                if (!any_shut && !deferred)
                    next_state = SFS_ST_NORMAL;
            default:
                next_state = SFS_ST_SHUT;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            state <= SFS_ST_NORMAL;
        else
            state <= next_state;
    end

    // Fault steering timer, counts only while deferring
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            defer_ms <= 16'h0000;
        else if (state != SFS_ST_DEFER)
            defer_ms <= 16'h0000;
        else if (ms_tick && defer_ms != 16'hFFFF)
            defer_ms <= defer_ms + 16'h0001;
    end

    // ---------------------------------------------------------------
    // Control outputs
    // ---------------------------------------------------------------
    sfs_steer_ctl_t next_ctl;

    always_comb
    begin
        next_ctl.steer_enable    = key_on && (next_state != SFS_ST_SHUT);
        next_ctl.fault_out       = key_on && (next_state != SFS_ST_SHUT);
        next_ctl.reduced_current = any_reduce;
        next_ctl.angle_max       = any_max_angle;
        next_ctl.hold_position   = (next_state == SFS_ST_DEFER)
                                   && any_hold_shut;
        next_ctl.traction_stop   = any_trac_stop;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            steer_ctl <= '0;
        else
            steer_ctl <= next_ctl;
    end

    // ---------------------------------------------------------------
    // Active code, lowest table position first
    // ---------------------------------------------------------------
    logic [5:0] next_code;

    always_comb
    begin
        next_code = `SFS_CODE_NONE;
        for (int i = NF - 1; i >= 0; i--)
        begin
            if (latched[i])
                next_code = TABLE[i].code;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            active_code   <= `SFS_CODE_NONE;
            fault_latched <= '0;
        end
        else
        begin
            active_code   <= next_code;
            fault_latched <= latched;
        end
    end

    // ---------------------------------------------------------------
    // Status LED
    // ---------------------------------------------------------------
    sfs_flasher u_flasher (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .ms_tick (ms_tick),
        .code    (active_code),
        .led     (status_led)
    );

endmodule // sfs_supervisor
`default_nettype wire

// *** verification/sfs_supervisor_sva.sv ***
/*
 * Port checker of the steer fault supervisor.
 * Assumes it is bound to sfs_supervisor and takes on its parameters.
 */
`timescale 1ns/1ps
`default_nettype none

module sfs_supervisor_chk
    import sfs_pkg::*;
#(
    parameter int NF        = 7,
    parameter int MS_CYCLES = 25000
)
(
    // Clock and reset
    input  wire logic           sys_clk,
    input  wire logic           arst_n,
    // Inputs
    input  wire logic [NF-1:0]  fault_detect,
    input  wire logic           keyswitch_input,
    input  wire logic           traction_stopped,
    input  wire logic [15:0]    fault_timeout_ms,
    // Outputs
    input  wire sfs_steer_ctl_t steer_ctl,
    input  wire logic [5:0]     active_code,
    input  wire logic [NF-1:0]  fault_latched,
    input  wire logic           status_led
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // ---------------------------------------------------------------
    // Deferred fault age
    // ---------------------------------------------------------------
    int defer_cnt;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            defer_cnt <= 0;
        else if (fault_latched[4] || fault_latched[6])
            defer_cnt <= defer_cnt + 1;
        else
            defer_cnt <= 0;
    end

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    property p_shut_now;
        (fault_detect & 7'h27) != 7'h00 |-> ##2 !steer_ctl.steer_enable
            && !steer_ctl.fault_out && steer_ctl.traction_stop;
    endproperty
    a_shut_now: assert property (p_shut_now)
        else $error("shutdown fault left steering on");

    property p_code;
        fault_detect[0] |-> ##2 active_code == 6'h0C && fault_latched[0];
    endproperty
    a_code: assert property (p_code)
        else $error("wrong active code");

    property p_warm;
        $fell(fault_detect[3]) ##1 !fault_detect[3] |-> ##[0:1]
            !fault_latched[3];
    endproperty
    a_warm: assert property (p_warm)
        else $error("undertemp fault did not clear");

    property p_cold_calm;
        fault_latched == 7'h08 |-> !steer_ctl.traction_stop
            && !steer_ctl.hold_position && !steer_ctl.reduced_current;
    endproperty
    a_cold_calm: assert property (p_cold_calm)
        else $error("warning fault changed control");

    property p_keep;
        keyswitch_input[*6] ##0 fault_latched[0] |=> fault_latched[0];
    endproperty
    a_keep: assert property (p_keep)
        else $error("latched fault lost with key on");

    property p_clear;
        (!keyswitch_input && fault_detect == 7'h00)[*6] |=>
            fault_latched == 7'h00 && !steer_ctl.steer_enable;
    endproperty
    a_clear: assert property (p_clear)
        else $error("key off did not clear faults");

    property p_warn_run;
        (!traction_stopped && keyswitch_input)[*6] ##0
        ($rose(fault_latched[4]) && (fault_latched & 7'h6F) == 7'h00
            && fault_timeout_ms != 16'h0000) |-> steer_ctl.steer_enable
            && steer_ctl.traction_stop && !steer_ctl.hold_position;
    endproperty
    a_warn_run: assert property (p_warn_run)
        else $error("warning fault did not keep steering");

    property p_hold;
        (!traction_stopped && keyswitch_input)[*6] ##0
        ($rose(fault_latched[6]) && (fault_latched & 7'h3F) == 7'h00
            && fault_timeout_ms != 16'h0000) |-> steer_ctl.steer_enable
            && steer_ctl.traction_stop && steer_ctl.hold_position;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold fault did not hold");

    property p_stop_done;
        ((fault_latched[4] || fault_latched[6]) && traction_stopped)[*6]
            |=> !steer_ctl.steer_enable && !steer_ctl.fault_out
            && !steer_ctl.hold_position;
    endproperty
    a_stop_done: assert property (p_stop_done)
        else $error("no shutdown after traction stop");

    property p_time_up;
        defer_cnt > (int'(fault_timeout_ms) + 1) * MS_CYCLES + 8
            |-> !steer_ctl.steer_enable;
    endproperty
    a_time_up: assert property (p_time_up)
        else $error("no shutdown after timeout");

    c_hold: cover property (steer_ctl.hold_position);
    c_defer: cover property ($fell(steer_ctl.steer_enable)
        && fault_latched[4]);
    c_led: cover property ($rose(status_led));
endmodule // sfs_supervisor_chk

bind sfs_supervisor sfs_supervisor_chk #(.NF(NF), .MS_CYCLES(MS_CYCLES))
    u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .fault_detect(fault_detect),
    .keyswitch_input(keyswitch_input), .traction_stopped(traction_stopped),
    .fault_timeout_ms(fault_timeout_ms), .steer_ctl(steer_ctl),
    .active_code(active_code), .fault_latched(fault_latched),
    .status_led(status_led));

`default_nettype wire

// *** verification/sfs_traction_model.sv ***
/*
 * Traction side model: reports the motor stopped some cycles after a
 * stop request. Assumes the supervisor clock; the bench sets the delay.
 */
`timescale 1ns/1ps
`default_nettype none

module sfs_traction_model
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Stop request and behaviour
    input  wire logic       stop_req,
    input  wire logic       responsive,
    input  wire logic [7:0] delay,
    // Motor stopped pin
    output logic            stopped
);
    logic [7:0] cnt;

    // Motor runs down over delay cycles; it never stops unasked
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt <= 8'h00;
        else if (!stop_req || !responsive)
            cnt <= 8'h00;
        else if (cnt != 8'hFF)
            cnt <= cnt + 8'h01;
    end

    assign stopped = responsive && stop_req && (cnt >= delay);
endmodule // sfs_traction_model

`default_nettype wire

// *** verification/sfs_supervisor_tb.sv ***
/*
 * Self-checking bench of the steer fault supervisor.
 * Assumes the checker is bound and the traction model drives the pin.
 */
`timescale 1ns/1ps
`default_nettype none

module sfs_supervisor_tb
    import sfs_pkg::*;
;
    localparam int MS = 2;

    logic           sys_clk          = 1'b0;
    logic           arst_n           = 1'b0;
    logic [6:0]     fault_detect     = 7'h00;
    logic           keyswitch_input  = 1'b0;
    logic [15:0]    fault_timeout_ms = 16'hFFFF;
    logic           responsive       = 1'b1;
    logic [7:0]     delay            = 8'h08;
    logic           traction_stopped;
    sfs_steer_ctl_t steer_ctl;
    logic [5:0]     active_code;
    logic [6:0]     fault_latched;
    logic           status_led;
    int             miscompares      = 0;
    int             cmp_count        = 0;
    int             seed             = 66972;
    int             sh[4]            = '{0, 1, 2, 5};
    int             tens;
    int             units;
    int             t0;
    int             tm;
    logic [6:0]     exp_l;

    always #20 sys_clk = ~sys_clk;

    sfs_supervisor #(.NF(7), .MS_CYCLES(MS)) dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .fault_detect(fault_detect),
        .keyswitch_input(keyswitch_input),
        .traction_stopped(traction_stopped),
        .fault_timeout_ms(fault_timeout_ms), .steer_ctl(steer_ctl),
        .active_code(active_code), .fault_latched(fault_latched),
        .status_led(status_led));

    sfs_traction_model model (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .stop_req(steer_ctl.traction_stop), .responsive(responsive),
        .delay(delay), .stopped(traction_stopped));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic int code_of(input int i);
        int t[7] = '{12, 13, 14, 15, 16, 17, 24};
        return t[i];
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk_ctl(input logic [5:0] e);
        cmp_count++;
        if (steer_ctl !== e)
            $display("[ERR] %0t ctl %b exp %b", $time, steer_ctl, e);
        if (steer_ctl !== e)
            miscompares++;
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] e);
        cmp_count++;
        if (got !== e)
            $display("[ERR] %0t value %h exp %h", $time, got, e);
        if (got !== e)
            miscompares++;
    endtask

    task automatic chk_num(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi)
            $display("[ERR] %0t got %0d not in %0d..%0d", $time, got, lo, hi);
        if (got < lo || got > hi)
            miscompares++;
    endtask

    task automatic key_cycle();
        keyswitch_input = 1'b0;
        step(8);
        keyswitch_input = 1'b1;
        step(8);
        chk_val({1'b0, fault_latched}, 8'h00);
        chk_ctl(6'h30);
    endtask

    task automatic wait_off(output int n);
        n = 0;
        while (steer_ctl.steer_enable !== 1'b0 && n < 20000)
        begin
            step(1);
            n++;
        end
    endtask

    // Syncs on a long dark spell, then counts the two pulse groups
    task automatic led_code(output int tn, output int un);
        int off;
        int w;
        int g;
        int n[2];
        off = 0;
        w = 0;
        g = 0;
        n = '{1, 0};
        while (w < 20000 * MS && !(status_led === 1'b1 && off >= 1500 * MS))
        begin
            off = (status_led === 1'b1) ? 0 : off + 1;
            step(1);
            w++;
        end
        off = 0;
        while (g < 2 && w < 20000 * MS)
        begin
            step(1);
            w++;
            if (status_led === 1'b1)
            begin
                if (off > 600 * MS)
                    g++;
                if (off > 0 && g < 2)
                    n[g]++;
                off = 0;
            end
            else
                off++;
        end
        tn = n[0];
        un = n[1];
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial
    begin
        step(10);
        arst_n = 1'b1;
        keyswitch_input = 1'b1;
        step(8);
        chk_ctl(6'h30);
        $display("reset test done");
        foreach (sh[k])
        begin
            exp_l = (7'h01 << sh[k]) | ((sh[k] == 5) ? 7'h40 : 7'h00);
            fault_detect = exp_l;
            step(1 + $unsigned($random(seed)) % 3);
            fault_detect = 7'h00;
            step(3);
            chk_ctl(6'h01);
            chk_val({2'b00, active_code}, 8'(code_of(sh[k])));
            step(20 + $unsigned($random(seed)) % 50);
            chk_val({1'b0, fault_latched}, {1'b0, exp_l});
            if (sh[k] == 0)
            begin
                led_code(tens, units);
                chk_num(tens, 1, 1);
                chk_num(units, 2, 2);
            end
            key_cycle();
        end
        $display("shutdown test done");
        fault_detect = 7'h08;
        step(4);
        chk_ctl(6'h30);
        chk_val({2'b00, active_code}, 8'h0F);
        fault_detect = 7'h00;
        step(4);
        chk_val({1'b0, fault_latched}, 8'h00);
        $display("undertemp test done");
        delay = 8'(8 + $unsigned($random(seed)) % 20);
        fault_timeout_ms = 16'h03E8;
        fault_detect = 7'h10;
        step(1);
        fault_detect = 7'h00;
        step(2);
        chk_ctl(6'h31);
        wait_off(t0);
        chk_num(t0, int'(delay) - 1, int'(delay) + 12);
        chk_ctl(6'h01);
        key_cycle();
        responsive = 1'b0;
        for (int r = 0; r < 2; r++)
        begin
            tm = (r == 0) ? 0 : 1 + $unsigned($random(seed)) % 4;
            fault_timeout_ms = 16'(tm);
            fault_detect = 7'h10;
            step(1);
            fault_detect = 7'h00;
            wait_off(t0);
            chk_num(t0, (tm - 1) * MS, (tm + 1) * MS + 8);
            key_cycle();
        end
        $display("warning test done");
        fault_timeout_ms = 16'hFFFF;
        fault_detect = 7'h40;
        step(1);
        fault_detect = 7'h00;
        step(2);
        chk_ctl(6'h33);
        led_code(tens, units);
        chk_num(tens, 2, 2);
        chk_num(units, 4, 4);
        delay = 8'(8 + $unsigned($random(seed)) % 40);
        responsive = 1'b1;
        wait_off(t0);
        chk_num(t0, int'(delay) - 1, int'(delay) + 12);
        chk_ctl(6'h01);
        key_cycle();
        $display("hold test done");
        conclude();
    end

    initial
    begin
        repeat (90000) @(posedge sys_clk);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end
endmodule // sfs_supervisor_tb

`default_nettype wire
